// *** timer_host_port.sv ***
`timescale 1ns/10ps

// Overview of operation
// R1: after each data transfer advance pointer, then refill prefetch latch.
// R2: data writes and load-pointer commands also trigger a prefetch.
// R3: data port reads present the prefetch latch, not the live register.
// R4: host reloads pointer before reading after any other command.
// R5: gate-edge saves write hold register without refreshing the prefetch.
// R6: host forces a new prefetch before reading a gate-captured hold value.
// R7: 8-bit read-only status holds byte pointer and each output state.
// R8: status shows TC high for code 000, low for code 100.
// R9: comparator drives output on counters 1-2; polarity depends on the whole output control code.
// R10: with comparator, code 100 shows active high, code 000 active low.
// R11: status readable at control port and through data port control group.
// R12: five groups of counter, load, hold, mode; counter itself hidden.
// R13: at terminal count reload counter from load or hold register.
// R14: hold register is alternate reload source and capture store.
// R15: counters 1-2 alarm comparator true while count equals alarm value.
// R16: master mode bits enable each comparator onto its output.
// R17: comparator active high for codes 001, 010; active low for 101.
// R18: host never asserts read and write strobes together.
// R19: strobes and port select ignored unless chip select is low.
// R20: commands are written on low data byte with port select high.
// R21: load-pointer codes select mode, load, and both hold registers.
// R22: pointer holds group, element and byte fields; byte toggles in 8-bit.
// R23: automatic pointer sequencing when master bit 14 is zero.
// R24: control port reads status, writes command; data port uses pointer.
module timer_host_port (
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic        cd,
	input  wire logic [15:0] data_in,
	output logic      [15:0] data_out,
	output logic      [1:0]  data_oe_n,
	input  wire logic [4:0]  count_in,
	input  wire logic [4:0]  gate_in,
	output logic      [4:0]  out_pin,
	output logic      [4:0]  out_oe_n
);

	localparam int NC = timer_port_pkg::NUM_COUNTERS;
	localparam int NA = timer_port_pkg::NUM_ALARMS;
	localparam int BW = timer_port_pkg::BYTE_W;
	localparam int WW = timer_port_pkg::WORD_W;

	// ==========================================================================
	// Reset release
	logic rst_meta_r;
	logic rst_n_r;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_r <= 1'b0;
			rst_n_r    <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_n_r    <= rst_meta_r;
		end
	end

	// ==========================================================================
	// Pin synchronisers
	logic [19:0] bus_lvl;
	logic [19:0] bus_rise;
	logic [9:0]  cnt_rise;

	pin_sync #(
		.WIDTH (timer_port_pkg::BUS_PINS),
		.IDLE  (timer_port_pkg::BUS_IDLE)
	) u_bus_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n_r),
		.pin_in   ({cs_n, rd_n, wr_n, cd, data_in}),
		.level    (bus_lvl),
		.rise     (bus_rise),
		.fall     ()
	);

	pin_sync #(
		.WIDTH (timer_port_pkg::CNT_PINS),
		.IDLE  (timer_port_pkg::CNT_IDLE)
	) u_cnt_sync (
		.core_clk (core_clk),
		.rst_n    (rst_n_r),
		.pin_in   ({gate_in, count_in}),
		.level    (),
		.rise     (cnt_rise),
		.fall     ()
	);

	// ==========================================================================
	// Bus decode
	logic        cs_act;
	logic        rd_act;
	logic        cd_lvl;
	logic [15:0] din;
	logic [7:0]  cmd;
	logic        rd_done;
	logic        wr_done;
	logic        data_rd_done;
	logic        data_wr_done;
	logic        data_xfer;
	logic        cmd_wr;
	logic        cmd_ptr;
	logic        cmd_load;
	logic        cmd_save;
	logic [4:0]  cmd_sel;

	// R19: chip select gating
	assign cs_act  = ~bus_lvl[timer_port_pkg::PIN_CS_N];
	assign rd_act  = cs_act & ~bus_lvl[timer_port_pkg::PIN_RD_N];
	assign cd_lvl  = bus_lvl[timer_port_pkg::PIN_CD];
	assign din     = bus_lvl[WW-1:0];
	assign cmd     = din[BW-1:0];
	// A transfer completes at the trailing edge of its strobe, with data held stable.
	assign rd_done = cs_act & bus_rise[timer_port_pkg::PIN_RD_N];
	assign wr_done = cs_act & bus_rise[timer_port_pkg::PIN_WR_N];

	// R24: port select steering
	assign data_rd_done = rd_done & ~cd_lvl;
	assign data_wr_done = wr_done & ~cd_lvl;
	assign data_xfer    = data_rd_done | data_wr_done;
	// R20: command on low byte
	assign cmd_wr   = wr_done & cd_lvl;
	assign cmd_ptr  = cmd_wr & (timer_port_pkg::cmd_opcode(cmd) == timer_port_pkg::CMD_OP_POINTER);
	assign cmd_load = cmd_wr & (timer_port_pkg::cmd_opcode(cmd) == timer_port_pkg::CMD_OP_LOAD);
	assign cmd_save = cmd_wr & (timer_port_pkg::cmd_opcode(cmd) == timer_port_pkg::CMD_OP_SAVE);
	assign cmd_sel  = timer_port_pkg::cmd_select(cmd);

	// ==========================================================================
	// Register storage
	logic [15:0] mode_r   [NC];
	logic [15:0] load_r   [NC];
	logic [15:0] hold_r   [NC];
	logic [15:0] count_r  [NC];
	logic [15:0] alarm_r  [NA];
	logic [15:0] master_r;
	logic [2:0]  grp_r;
	logic [1:0]  elem_r;
	logic        byte_ptr_r;
	logic [15:0] prefetch_r;
	logic        pf_req_r;
	logic [NC-1:0] tc_r;
	logic [NC-1:0] toggle_r;
	logic [NC-1:0] out_r;
	logic [NC-1:0] oe_n_r;
	logic [15:0] data_out_r;

	logic        bus16;
	logic        seq_dis;
	logic        grp_is_cnt;
	logic [2:0]  grp_idx;
	logic        word_done;
	logic [NC-1:0] out_lvl;
	logic [7:0]  status;
	logic [15:0] sel_word;

	assign bus16      = master_r[timer_port_pkg::MM_BUS16];
	assign seq_dis    = master_r[timer_port_pkg::MM_SEQ_DIS];
	assign grp_is_cnt = (grp_r >= timer_port_pkg::GRP_FIRST) && (grp_r <= timer_port_pkg::GRP_LAST);
	assign grp_idx    = grp_r - timer_port_pkg::GRP_FIRST;
	assign word_done  = bus16 | ~byte_ptr_r;

	// ==========================================================================
	// Helper functions
	function automatic logic [2:0] next_grp(input logic [2:0] g);
		if ((g >= timer_port_pkg::GRP_LAST) || (g < timer_port_pkg::GRP_FIRST)) begin
			return timer_port_pkg::GRP_FIRST;
		end
		return g + 3'h1;
	endfunction

	function automatic logic [4:0] next_ptr(input logic [2:0] g, input logic [1:0] e);
		logic [2:0] gn;
		logic [1:0] en;
		gn = g;
		en = e;
		if (g == timer_port_pkg::GRP_CONTROL) begin
			// Control cycle walks alarm, alarm, master; status-only pointer stays put.
			if (e == timer_port_pkg::ELEM_MASTER) begin
				en = timer_port_pkg::ELEM_ALARM1;
			end else if (e != timer_port_pkg::ELEM_STATUS) begin
				en = e + 2'h1;
			end
		end else if (e == timer_port_pkg::ELEM_HOLD_CYC) begin
			gn = next_grp(g);
		end else if (e == timer_port_pkg::ELEM_HOLD) begin
			en = timer_port_pkg::ELEM_MODE;
			gn = next_grp(g);
		end else begin
			en = e + 2'h1;
		end
		return {gn, en};
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] d,
	                                      input logic wide, input logic low_byte);
		if (wide) begin
			return d;
		end
		if (low_byte) begin
			return {old[WW-1:BW], d[BW-1:0]};
		end
		return {d[BW-1:0], old[BW-1:0]};
	endfunction

	function automatic logic out_state(input logic [2:0] oc, input logic tc, input logic tog,
	                                   input logic cmp_en, input logic cmp);
		if (cmp_en) begin
			// R10: comparator status polarity
			if (oc == timer_port_pkg::OC_HIGHZ) begin
				return cmp;
			end
			// R17: comparator polarity codes
			if ((oc == timer_port_pkg::OC_TC_HIGH) || (oc == timer_port_pkg::OC_TOGGLE)) begin
				return cmp;
			end
			// R9: active low otherwise
			return ~cmp;
		end
		if (oc == timer_port_pkg::OC_TOGGLE) begin
			return tog;
		end
		// R8: TC status polarity
		if ((oc == timer_port_pkg::OC_HIGHZ) || (oc == timer_port_pkg::OC_TC_LOW)) begin
			return ~tc;
		end
		return tc;
	endfunction

	// ==========================================================================
	// Data pointer
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			grp_r      <= timer_port_pkg::PTR_GRP_RESET;
			elem_r     <= timer_port_pkg::PTR_ELEM_RESET;
			byte_ptr_r <= 1'b1;
		end else if (cmd_ptr) begin
			// R21: load-pointer decode
			grp_r      <= timer_port_pkg::cmd_group(cmd);
			elem_r     <= timer_port_pkg::cmd_element(cmd);
			byte_ptr_r <= 1'b1;
		end else if (data_xfer) begin
			// R22: byte pointer toggle
			byte_ptr_r <= bus16 | ~byte_ptr_r;
			// R23: automatic sequencing
			if (word_done && !seq_dis) begin
				{grp_r, elem_r} <= next_ptr(grp_r, elem_r);
			end
		end
	end

	// ==========================================================================
	// Prefetch latch
	// The latch is refilled the cycle after the pointer moves, so it sees the new
	// pointer and any word just written.
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pf_req_r   <= 1'b0;
			prefetch_r <= timer_port_pkg::REG_RESET;
		end else begin
			// R2: prefetch after writes and pointer load
			pf_req_r <= cmd_ptr | data_xfer;
			// R1: refill after pointer update
			if (pf_req_r) begin
				prefetch_r <= sel_word;
			end
		end
	end

	// R7: status layout
	assign status = {timer_port_pkg::STAT_PAD, out_lvl, byte_ptr_r};

	always_comb begin
		sel_word = timer_port_pkg::REG_RESET;
		if (grp_r == timer_port_pkg::GRP_CONTROL) begin
			// R11: status in control group
			unique case (elem_r)
				timer_port_pkg::ELEM_ALARM1: sel_word = alarm_r[0];
				timer_port_pkg::ELEM_ALARM2: sel_word = alarm_r[1];
				timer_port_pkg::ELEM_MASTER: sel_word = master_r;
				timer_port_pkg::ELEM_STATUS: sel_word = {timer_port_pkg::BYTE_ZERO, status};
			endcase
		end else if (grp_is_cnt) begin
			unique case (elem_r)
				timer_port_pkg::ELEM_MODE:     sel_word = mode_r[grp_idx];
				timer_port_pkg::ELEM_LOAD:     sel_word = load_r[grp_idx];
				timer_port_pkg::ELEM_HOLD:     sel_word = hold_r[grp_idx];
				timer_port_pkg::ELEM_HOLD_CYC: sel_word = hold_r[grp_idx];
			endcase
		end
	end

	// ==========================================================================
	// Host writes to mode, load, alarm and master registers
	// R12: host-writable group registers
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			for (int i = 0; i < NC; i++) begin
				mode_r[i] <= timer_port_pkg::REG_RESET;
				load_r[i] <= timer_port_pkg::REG_RESET;
			end
			for (int i = 0; i < NA; i++) begin
				alarm_r[i] <= timer_port_pkg::REG_RESET;
			end
			master_r <= timer_port_pkg::MASTER_RESET;
		end else if (data_wr_done) begin
			if (grp_is_cnt && (elem_r == timer_port_pkg::ELEM_MODE)) begin
				mode_r[grp_idx] <= merge(mode_r[grp_idx], din, bus16, byte_ptr_r);
			end
			if (grp_is_cnt && (elem_r == timer_port_pkg::ELEM_LOAD)) begin
				load_r[grp_idx] <= merge(load_r[grp_idx], din, bus16, byte_ptr_r);
			end
			if ((grp_r == timer_port_pkg::GRP_CONTROL) && (elem_r == timer_port_pkg::ELEM_ALARM1)) begin
				alarm_r[0] <= merge(alarm_r[0], din, bus16, byte_ptr_r);
			end
			if ((grp_r == timer_port_pkg::GRP_CONTROL) && (elem_r == timer_port_pkg::ELEM_ALARM2)) begin
				alarm_r[1] <= merge(alarm_r[1], din, bus16, byte_ptr_r);
			end
			if ((grp_r == timer_port_pkg::GRP_CONTROL) && (elem_r == timer_port_pkg::ELEM_MASTER)) begin
				master_r <= merge(master_r, din, bus16, byte_ptr_r);
			end
		end
	end

	// ==========================================================================
	// Hold registers
	// A hardware capture beats a host write in the same cycle; the count it
	// preserves cannot be recovered later, the host word can be rewritten.
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			for (int i = 0; i < NC; i++) begin
				hold_r[i] <= timer_port_pkg::REG_RESET;
			end
		end else begin
			for (int i = 0; i < NC; i++) begin
				// R14: software save or hardware capture
				if (cmd_save && cmd_sel[i]) begin
					hold_r[i] <= count_r[i];
				// R5: gate-edge save, prefetch untouched
				end else if (cnt_rise[NC+i] && mode_r[i][timer_port_pkg::MODE_GATE_SAVE_BIT]) begin
					hold_r[i] <= count_r[i];
				end else if (data_wr_done && grp_is_cnt && (grp_idx == 3'(i)) &&
				             ((elem_r == timer_port_pkg::ELEM_HOLD) ||
				              (elem_r == timer_port_pkg::ELEM_HOLD_CYC))) begin
					hold_r[i] <= merge(hold_r[i], din, bus16, byte_ptr_r);
				end
			end
		end
	end

	// ==========================================================================
	// Counters
	// Counting is a plain down-count on each synchronised source edge; no arming,
	// gating or source selection exists anywhere in this design.
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			for (int i = 0; i < NC; i++) begin
				count_r[i] <= timer_port_pkg::REG_RESET;
			end
			tc_r     <= '0;
			toggle_r <= '0;
		end else begin
			for (int i = 0; i < NC; i++) begin
				if (cmd_load && cmd_sel[i]) begin
					count_r[i] <= mode_r[i][timer_port_pkg::MODE_RELOAD_HOLD] ? hold_r[i] : load_r[i];
				end else if (cnt_rise[i]) begin
					// R13: reload at terminal count
					if (count_r[i] == timer_port_pkg::COUNT_TC_AT) begin
						count_r[i] <= mode_r[i][timer_port_pkg::MODE_RELOAD_HOLD] ? hold_r[i] : load_r[i];
					end else begin
						count_r[i] <= count_r[i] - timer_port_pkg::COUNT_STEP;
					end
				end
				if (cnt_rise[i]) begin
					tc_r[i] <= (count_r[i] == timer_port_pkg::COUNT_TC_AT);
					if (count_r[i] == timer_port_pkg::COUNT_TC_AT) begin
						toggle_r[i] <= ~toggle_r[i];
					end
				end
			end
		end
	end

	// ==========================================================================
	// Output state and pins
	always_comb begin
		for (int i = 0; i < NC; i++) begin
			out_lvl[i] = out_state(mode_r[i][timer_port_pkg::MODE_OC_LSB +: 3], tc_r[i], toggle_r[i], 1'b0, 1'b0);
		end
		for (int i = 0; i < NA; i++) begin
			// R15: alarm equality compare
			// R16: comparator replaces output
			out_lvl[i] = out_state(mode_r[i][timer_port_pkg::MODE_OC_LSB +: 3], tc_r[i], toggle_r[i],
			                       master_r[timer_port_pkg::MM_CMP1_EN + i], count_r[i] == alarm_r[i]);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			out_r  <= '0;
			oe_n_r <= '1;
		end else begin
			for (int i = 0; i < NC; i++) begin
				out_r[i] <= out_lvl[i];
				// The high-impedance option only pulls the pin low.
				if (mode_r[i][timer_port_pkg::MODE_OC_LSB +: 3] == timer_port_pkg::OC_HIGHZ) begin
					oe_n_r[i] <= out_lvl[i];
				end else begin
					oe_n_r[i] <= 1'b0;
				end
			end
		end
	end

	assign out_pin  = out_r;
	assign out_oe_n = oe_n_r;

	// ==========================================================================
	// Read data drivers
	always_ff @(posedge core_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			data_out_r <= timer_port_pkg::REG_RESET;
		end else if (cd_lvl) begin
			// R24: control port returns live status
			data_out_r <= {timer_port_pkg::BYTE_ZERO, status};
		end else if (bus16) begin
			// R3: data reads come from the latch
			data_out_r <= prefetch_r;
		end else if (byte_ptr_r) begin
			data_out_r <= {timer_port_pkg::BYTE_ZERO, prefetch_r[BW-1:0]};
		end else begin
			data_out_r <= {timer_port_pkg::BYTE_ZERO, prefetch_r[WW-1:BW]};
		end
	end

	assign data_out     = data_out_r;
	assign data_oe_n[0] = ~rd_act;
	assign data_oe_n[1] = ~(rd_act & ~cd_lvl & bus16);

endmodule // timer_host_port

// *** timer_port_pkg.sv ***
package timer_port_pkg;

	// ==========================================================================
	// Sizes
	localparam int NUM_COUNTERS = 5;
	localparam int NUM_ALARMS   = 2;
	localparam int WORD_W       = 16;
	localparam int BYTE_W       = 8;
	localparam int BUS_PINS     = 20;
	localparam int CNT_PINS     = 10;

	// ==========================================================================
	// Data pointer codes
	localparam logic [2:0] GRP_FIRST     = 3'h1;
	localparam logic [2:0] GRP_LAST      = 3'h5;
	localparam logic [2:0] GRP_CONTROL   = 3'h7;
	localparam logic [1:0] ELEM_MODE     = 2'h0;
	localparam logic [1:0] ELEM_LOAD     = 2'h1;
	localparam logic [1:0] ELEM_HOLD     = 2'h2;
	localparam logic [1:0] ELEM_HOLD_CYC = 2'h3;
	localparam logic [1:0] ELEM_ALARM1   = 2'h0;
	localparam logic [1:0] ELEM_ALARM2   = 2'h1;
	localparam logic [1:0] ELEM_MASTER   = 2'h2;
	localparam logic [1:0] ELEM_STATUS   = 2'h3;
	localparam logic [2:0] PTR_GRP_RESET = 3'h1;
	localparam logic [1:0] PTR_ELEM_RESET = 2'h0;

	// ==========================================================================
	// Command layout and opcodes
	localparam int         CMD_OP_LSB     = 5;
	localparam int         CMD_ELEM_LSB   = 3;
	localparam int         CMD_GRP_LSB    = 0;
	localparam int         CMD_SEL_LSB    = 0;
	localparam logic [2:0] CMD_OP_POINTER = 3'h0;
	localparam logic [2:0] CMD_OP_LOAD    = 3'h2;
	localparam logic [2:0] CMD_OP_SAVE    = 3'h5;

	// ==========================================================================
	// Master mode and counter mode fields
	localparam int MM_CMP1_EN         = 2;
	localparam int MM_BUS16           = 13;
	localparam int MM_SEQ_DIS         = 14;
	localparam int MODE_OC_LSB        = 0;
	localparam int MODE_GATE_SAVE_BIT = 5;
	localparam int MODE_RELOAD_HOLD   = 12;

	localparam logic [2:0] OC_LOWZ_GND  = 3'h0;
	localparam logic [2:0] OC_TC_HIGH   = 3'h1;
	localparam logic [2:0] OC_TOGGLE    = 3'h2;
	localparam logic [2:0] OC_HIGHZ     = 3'h4;
	localparam logic [2:0] OC_TC_LOW    = 3'h5;

	// ==========================================================================
	// Reset values and constants
	localparam logic [15:0] REG_RESET    = 16'h0000;
	localparam logic [15:0] MASTER_RESET = 16'h0000;
	localparam logic [15:0] COUNT_TC_AT  = 16'h0001;
	localparam logic [15:0] COUNT_STEP   = 16'h0001;
	localparam logic [1:0]  STAT_PAD     = 2'h0;
	localparam logic [7:0]  BYTE_ZERO    = 8'h00;
	// Pin order {cs_n, rd_n, wr_n, cd, data[15:0]}; strobes idle high.
	localparam logic [19:0] BUS_IDLE     = 20'hE0000;
	localparam logic [9:0]  CNT_IDLE     = 10'h000;
	localparam int          PIN_CS_N     = 19;
	localparam int          PIN_RD_N     = 18;
	localparam int          PIN_WR_N     = 17;
	localparam int          PIN_CD       = 16;

	function automatic logic [2:0] cmd_opcode(input logic [7:0] c);
		return c[CMD_OP_LSB +: 3];
	endfunction

	function automatic logic [1:0] cmd_element(input logic [7:0] c);
		return c[CMD_ELEM_LSB +: 2];
	endfunction

	function automatic logic [2:0] cmd_group(input logic [7:0] c);
		return c[CMD_GRP_LSB +: 3];
	endfunction

	function automatic logic [4:0] cmd_select(input logic [7:0] c);
		return c[CMD_SEL_LSB +: 5];
	endfunction

endpackage

// *** pin_sync.sv ***
`timescale 1ns/10ps

module pin_sync #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE  = '0
) (
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise,
	output logic      [WIDTH-1:0] fall
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] level_r;
	logic [WIDTH-1:0] level_nxt;

	// ==========================================================================
	// Three stages; a change counts only once stages two and three agree.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_r    <= IDLE;
			s2_r    <= IDLE;
			s3_r    <= IDLE;
			level_r <= IDLE;
		end else begin
			s1_r    <= pin_in;
			s2_r    <= s1_r;
			s3_r    <= s2_r;
			level_r <= level_nxt;
		end
	end

	always_comb begin
		level_nxt = (s2_r & s3_r) | (level_r & (s2_r | s3_r));
	end

	assign level = level_r;
	assign rise  = level_nxt & ~level_r;
	assign fall  = ~level_nxt & level_r;

endmodule // pin_sync

// *** timer_port_checker_assertions.sv ***
`timescale 1ns/10ps
// ============================================================
// Port checker
module timer_port_checker (
	input wire logic        core_clk,
	input wire logic        arst_n,
	input wire logic        cs_n,
	input wire logic        rd_n,
	input wire logic        wr_n,
	input wire logic        cd,
	input wire logic [15:0] data_in,
	input wire logic [15:0] data_out,
	input wire logic [1:0]  data_oe_n,
	input wire logic [4:0]  count_in,
	input wire logic [4:0]  gate_in,
	input wire logic [4:0]  out_pin,
	input wire logic [4:0]  out_oe_n
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	logic ctl_rd;
	logic dat_rd;
	assign ctl_rd = !cs_n && !rd_n && wr_n && cd;
	assign dat_rd = !cs_n && !rd_n && wr_n && !cd;
	// Six cycles cover the pin synchroniser before a level counts.
	idle_no_drive_a: assert property (cs_n [*6] |-> data_oe_n == 2'h3)
		else $error("data drivers on while chip is not selected");
	no_read_quiet_a: assert property (rd_n [*6] |-> data_oe_n == 2'h3)
		else $error("data drivers on without a read strobe");
	read_drives_a: assert property ((!cs_n && !rd_n && wr_n) [*6] |-> !data_oe_n[0])
		else $error("low byte not driven during a read");
	prefetch_stable_a: assert property (dat_rd [*8] |-> $stable(data_out))
		else $error("data port read value moved during the strobe");
	ctl_narrow_a: assert property (ctl_rd [*6] |-> data_oe_n[1])
		else $error("high byte driven on a control port read");
	ctl_upper_zero_a: assert property (ctl_rd [*8] |-> data_out[15:8] == 8'h00)
		else $error("control port read has upper byte set");
	status_pad_a: assert property (ctl_rd [*8] |-> data_out[7:6] == 2'h0)
		else $error("unused status bits set");
	status_mirror_a: assert property ((ctl_rd && $stable(out_pin)) [*8] |-> data_out[5:1] == out_pin)
		else $error("status output bits differ from output pins");
	cover property (dat_rd [*8]);
	cover property (ctl_rd [*8]);
	cover property ($rose(out_pin[0]));
endmodule // timer_port_checker

bind timer_host_port timer_port_checker chk (.core_clk, .arst_n, .cs_n, .rd_n, .wr_n, .cd, .data_in,
	.data_out, .data_oe_n, .count_in, .gate_in, .out_pin, .out_oe_n);

// *** host_bus_model.sv ***
`timescale 1ns/10ps
// ============================================================
// Host processor on the strobed bus
module host_bus_model (
	input  wire logic        core_clk,
	input  wire logic [15:0] data_out,
	output logic             cs_n,
	output logic             rd_n,
	output logic             wr_n,
	output logic             cd,
	output logic      [15:0] data_in
);
	initial begin
		cs_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		cd = 1'b0;
		data_in = 16'hFFFF;
	end
	// one strobe, framed by setup and hold
	task automatic xfer(input logic sel_n, input logic c, input logic rd, input logic [15:0] d,
		output logic [15:0] q);
		@(posedge core_clk);
		cs_n <= sel_n;
		cd <= c;
		if (!rd) data_in <= d;
		repeat (5) @(posedge core_clk);
		rd_n <= !rd;
		wr_n <= rd;
		repeat (8) @(posedge core_clk);
		q = data_out;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		repeat (6) @(posedge core_clk);
		cs_n <= 1'b1;
		// A released bus must not keep showing the old value.
		data_in <= ~data_in;
	endtask
endmodule // host_bus_model

// *** timer_host_port_bench.sv ***
`timescale 1ns/10ps
// ============================================================
// Bench for the host register port
module timer_host_port_bench;
	logic        core_clk;
	logic        arst_n;
	logic        cs_n;
	logic        rd_n;
	logic        wr_n;
	logic        cd;
	logic [15:0] data_in;
	logic [15:0] data_out;
	logic [1:0]  data_oe_n;
	logic [4:0]  count_in;
	logic [4:0]  gate_in;
	logic [4:0]  out_pin;
	logic [4:0]  out_oe_n;
	int          n_mismatch = 0;
	int          tests_run = 0;

	timer_host_port dut (.core_clk(core_clk), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
		.cd(cd), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .count_in(count_in),
		.gate_in(gate_in), .out_pin(out_pin), .out_oe_n(out_oe_n));
	host_bus_model host (.core_clk(core_clk), .data_out(data_out), .cs_n(cs_n), .rd_n(rd_n),
		.wr_n(wr_n), .cd(cd), .data_in(data_in));

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic c, input logic [15:0] d);
		logic [15:0] q;
		host.xfer(1'b0, c, 1'b0, d, q);
	endtask

	task automatic rd(input logic c, input logic [15:0] exp, input string what);
		logic [15:0] q;
		host.xfer(1'b0, c, 1'b1, 16'h0000, q);
		check(what, q, exp);
	endtask

	task automatic pulse(input logic g, input int i);
		if (g) gate_in <= 5'(1 << i);
		else count_in <= 5'(1 << i);
		repeat (6) @(posedge core_clk);
		gate_in <= 5'h00;
		count_in <= 5'h00;
		repeat (6) @(posedge core_clk);
	endtask

	task automatic out1(input logic exp);
		repeat (6) @(posedge core_clk);
		check("out_pin0", {15'h0000, out_pin[0]}, {15'h0000, exp});
	endtask

	task automatic pins(input logic [4:0] exp, input logic [4:0] oe);
		repeat (6) @(posedge core_clk);
		check("out_pin", {11'h000, out_pin}, {11'h000, exp});
		check("out_oe_n", {11'h000, out_oe_n}, {11'h000, oe});
	endtask

	initial begin
		repeat (100000) @(posedge core_clk);
		n_mismatch++;
		results();
	end

	initial begin
		logic [15:0] q;
		arst_n = 1'b0;
		count_in = 5'h00;
		gate_in = 5'h00;
		repeat (12) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (10) @(posedge core_clk);
		check("oe_n", {14'h0000, data_oe_n}, 16'h0003);
		check("out_pin", {11'h000, out_pin}, 16'h0000);
		// 8-bit bus: bytes travel on the low lines, upper three held high.
		wr(1'b1, 16'hE00A);
		rd(1'b1, 16'h0001, "status byte ptr");
		wr(1'b0, 16'hE05A);
		wr(1'b0, 16'hE0C3);
		wr(1'b1, 16'hE00A);
		rd(1'b0, 16'h005A, "load2 low");
		rd(1'b1, 16'h0000, "status toggled");
		rd(1'b0, 16'h00C3, "load2 high");
		wr(1'b1, 16'hE017);
		wr(1'b0, 16'hE000);
		wr(1'b0, 16'hE020);
		// 16-bit bus from here on.
		wr(1'b1, 16'hFF09);
		wr(1'b0, 16'hA5C3);
		wr(1'b0, 16'h1234);
		rd(1'b1, 16'h0001, "status 16-bit");
		wr(1'b1, 16'hFF09);
		host.xfer(1'b1, 1'b0, 1'b0, 16'hDEAD, q);
		rd(1'b0, 16'hA5C3, "load1");
		rd(1'b0, 16'h1234, "hold1 sequenced");
		wr(1'b1, 16'hFF1F);
		rd(1'b0, 16'h0001, "status data port");
		wr(1'b1, 16'hFF17);
		wr(1'b0, 16'h6000);
		wr(1'b1, 16'hFF09);
		wr(1'b0, 16'h1111);
		wr(1'b0, 16'h0003);
		rd(1'b0, 16'h0003, "load1 no sequencing");
		wr(1'b1, 16'hFF41);
		pulse(1'b0, 0);
		pulse(1'b0, 0);
		pulse(1'b0, 0);
		out1(1'b1);
		wr(1'b1, 16'hFF03);
		wr(1'b0, 16'h0004);
		rd(1'b1, 16'h000B, "status outputs");
		pulse(1'b0, 0);
		out1(1'b0);
		wr(1'b1, 16'hFFA1);
		wr(1'b1, 16'hFF11);
		rd(1'b0, 16'h0002, "hold1 saved");
		wr(1'b1, 16'hFF07);
		wr(1'b0, 16'h0002);
		wr(1'b1, 16'hFF17);
		wr(1'b0, 16'h6004);
		wr(1'b1, 16'hFF01);
		wr(1'b0, 16'h0001);
		out1(1'b1);
		pulse(1'b0, 0);
		out1(1'b0);
		wr(1'b0, 16'h0005);
		out1(1'b1);
		wr(1'b0, 16'h0004);
		out1(1'b0);
		wr(1'b0, 16'h0021);
		wr(1'b1, 16'hFF11);
		pulse(1'b1, 0);
		rd(1'b0, 16'h0002, "stale prefetch");
		wr(1'b1, 16'hFF11);
		rd(1'b0, 16'h0001, "gate capture");
		// Counter 2 toggles and reloads from its hold register, period two.
		wr(1'b1, 16'hFF02);
		wr(1'b0, 16'h1002);
		wr(1'b1, 16'hFF1A);
		wr(1'b0, 16'h0002);
		wr(1'b1, 16'hFF42);
		pulse(1'b0, 1);
		pulse(1'b0, 1);
		pins(5'h06, 5'h04);
		pulse(1'b0, 1);
		pulse(1'b0, 1);
		pins(5'h04, 5'h04);
		results();
	end
endmodule // timer_host_port_bench
